// ---- design/smc_top.sv ----
/*
  Serial slave front end: op-code capture and decode, status register,
  write latch, status read and status write data phases.
  Assumes select, serial clock, serial in and protect pin are asynchronous
  pins sampled by i_mclk at well above twice the serial clock rate; the
  nonvolatile image is held outside and presented on i_nv_init at reset.
*/
// Notes on behaviour
// RQ1: works with serial modes zero and three; host picks one.
// RQ2: slave only; select and serial clock are inputs, never driven.
// RQ3: host may join serial in and out onto one shared line.
// RQ4: bit 7 is stored lock enable; with protect pin it gates status writes.
// RQ5: bits 6 to 4 store written values and read back, no function.
// RQ6: bits 3 and 2 store protect size, read and written by status commands.
// RQ7: bit 1 write latch set by set command, cleared by clear command.
// RQ8: status write never changes the write latch bit.
// RQ9: write latch cleared at power-up and on clear command.
// RQ10: write latch stays set after status, serial-number, special-sector writes.
// RQ11: bit 0 always reads zero, no command alters it.
// RQ12: first 8 bits after select falls are decoded; fourteen valid commands.
// RQ13: set latch 06, clear latch 04, status read 05.
// RQ14: status write 01, device id read 9F, unique id read 4C.
// RQ15: array read 03, array write 02, fast array read 0B.
// RQ16: special write 42, special read 4B, fast special read 49.
// RQ17: serial-number write C2, serial-number read C3.
// RQ18: host never sends codes outside the fourteen valid ones; the bench sends five reserved codes to see them ignored.
// RQ19: select rising mid op-code discards it; nothing executes.
// RQ20: select high means standby, output released, other inputs ignored.
// RQ21: input sampled on rising serial clock, output changes on falling.
// RQ22: host sets write latch before any write command; the bench also sends writes with the latch clear, to see them refused.
// RQ23: bit counter clears when select rises; next frame starts fresh.
// RQ24: at power-up stored bits return last values, write latch reads zero.
module smc_top (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  // serial pins
  input  wire logic               i_cs_n,
  input  wire logic               i_sck,
  input  wire logic               i_si,
  output logic                    o_so,
  output logic                    o_so_oe,
  // protect pin, low protects
  input  wire logic               i_wp_n,
  // nonvolatile image store
  input  wire logic [7:0]         i_nv_init,
  output logic      [7:0]         o_nv_data,
  output logic                    o_nv_store,
  // command report
  output logic                    o_cmd_strobe,
  output logic      [7:0]         o_cmd_code,
  output smc_pkg::smc_cmd_t       o_cmd_kind,
  output logic                    o_cmd_known,
  output logic                    o_cmd_abort,
  // state view
  output logic      [7:0]         o_status,
  output logic                    o_selected,
  output logic                    o_mode3
);
  import smc_pkg::*;

  typedef enum logic [2:0] {
    SMC_ST_IDLE,
    SMC_ST_OPCODE,
    SMC_ST_STAT_RD,
    SMC_ST_STAT_WR,
    SMC_ST_IGNORE
  } smc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_q;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       wp_n_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;

  // si and sck share the same latency, so sampled data stays aligned
  smc_sync #(
    .W    (4),
    .IDLE (SMC_PIN_IDLE)
  ) u_sync (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    ({i_wp_n, i_si, i_sck, i_cs_n}),
    .o_q    (pin_q),
    .o_rise (pin_rise),
    .o_fall (pin_fall)
  );

  assign cs_n_s   = pin_q[0];
  assign sck_s    = pin_q[1];
  assign si_s     = pin_q[2];
  assign wp_n_s   = pin_q[3];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign cs_rise  = pin_rise[0];
  assign cs_fall  = pin_fall[0];

  ////////////////////////////////////////////////////////////////////////////
  // frame state
  smc_state_t state_r;
  smc_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] out_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic       active;

  smc_dec_if dec_bus ();

  smc_opdec u_dec (
    .dec (dec_bus)
  );

  assign rx_byte      = {shift_r[6:0], si_s};
  assign dec_bus.code = rx_byte;
  // standby while select is high: every other pin is ignored
  assign active       = !cs_n_s && (state_r != SMC_ST_IDLE); // [RQ20]
  assign byte_done    = active && sck_rise && (bit_cnt_r == SMC_CNT_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMC_ST_IDLE: begin
        if (!cs_n_s) begin
          state_nxt = SMC_ST_OPCODE; // [RQ12]
        end
      end
      SMC_ST_OPCODE: begin
        if (byte_done) begin
          case (dec_bus.cmd)
            SMC_CMD_STATUS_READ:  state_nxt = SMC_ST_STAT_RD;
            SMC_CMD_STATUS_WRITE: state_nxt = SMC_ST_STAT_WR;
            // data phases of other commands are served elsewhere
            default:              state_nxt = SMC_ST_IGNORE;
          endcase
        end
      end
      SMC_ST_STAT_WR: begin
        if (byte_done) begin
          state_nxt = SMC_ST_IGNORE;
        end
      end
      SMC_ST_STAT_RD: state_nxt = SMC_ST_STAT_RD;
      SMC_ST_IGNORE:  state_nxt = SMC_ST_IGNORE;
      default:        state_nxt = SMC_ST_IDLE;
    endcase
    if (cs_n_s) begin
      state_nxt = SMC_ST_IDLE; // [RQ19] [RQ20]
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= SMC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counter cleared by deselect so a fresh op-code always starts at bit 7
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
    end else if (cs_n_s || state_r == SMC_ST_IDLE) begin
      bit_cnt_r <= 3'h0; // [RQ23]
      shift_r   <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1; // [RQ21]
      shift_r   <= rx_byte;
    end
  end

  // serial clock level at select fall tells mode zero from mode three
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mode3 <= 1'b0;
    end else if (cs_fall) begin
      o_mode3 <= sck_s; // [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command report
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_strobe <= 1'b0;
      o_cmd_code   <= 8'h00;
      o_cmd_kind   <= SMC_CMD_NONE;
      o_cmd_known  <= 1'b0;
    end else begin
      o_cmd_strobe <= 1'b0;
      if (byte_done && state_r == SMC_ST_OPCODE) begin
        o_cmd_strobe <= 1'b1; // [RQ12]
        o_cmd_code   <= rx_byte;
        o_cmd_kind   <= dec_bus.cmd;
        o_cmd_known  <= dec_bus.known;
      end
    end
  end

  // partial op-code: flag it, execute nothing
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_abort <= 1'b0;
    end else begin
      o_cmd_abort <= cs_rise && (state_r == SMC_ST_OPCODE) && (bit_cnt_r != 3'h0); // [RQ19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register
  logic       lock_r;
  logic [2:0] spare_r;
  logic [1:0] size_r;
  logic       write_latch_r;
  logic       restore_r;
  logic       wr_allowed;
  logic       stat_wr_hit;
  logic [7:0] status_view;

  // a set lock bit with the protect pin low refuses status writes
  assign wr_allowed  = write_latch_r && !(lock_r && !wp_n_s); // [RQ4]
  assign stat_wr_hit = byte_done && (state_r == SMC_ST_STAT_WR) && wr_allowed;

  always_comb begin
    status_view                                 = 8'h00;
    status_view[SMC_BIT_LOCK]                   = lock_r;        // [RQ4]
    status_view[SMC_BIT_SPARE_HI:SMC_BIT_SPARE_LO] = spare_r;    // [RQ5]
    status_view[SMC_BIT_SIZE_HI:SMC_BIT_SIZE_LO]   = size_r;     // [RQ6]
    status_view[SMC_BIT_LATCH]                  = write_latch_r; // [RQ7]
    status_view[SMC_BIT_ZERO]                   = 1'b0;          // [RQ11]
  end

  // stored bits have no value of their own at reset; restore runs once after release
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      restore_r <= 1'b1;
      lock_r    <= SMC_NV_RST[SMC_BIT_LOCK];
      spare_r   <= SMC_NV_RST[SMC_BIT_SPARE_HI:SMC_BIT_SPARE_LO];
      size_r    <= SMC_NV_RST[SMC_BIT_SIZE_HI:SMC_BIT_SIZE_LO];
    end else if (restore_r) begin
      restore_r <= 1'b0;
      lock_r    <= i_nv_init[SMC_BIT_LOCK]; // [RQ24]
      spare_r   <= i_nv_init[SMC_BIT_SPARE_HI:SMC_BIT_SPARE_LO];
      size_r    <= i_nv_init[SMC_BIT_SIZE_HI:SMC_BIT_SIZE_LO];
    end else if (stat_wr_hit) begin
      lock_r    <= rx_byte[SMC_BIT_LOCK];                        // [RQ4]
      spare_r   <= rx_byte[SMC_BIT_SPARE_HI:SMC_BIT_SPARE_LO];   // [RQ5]
      size_r    <= rx_byte[SMC_BIT_SIZE_HI:SMC_BIT_SIZE_LO];     // [RQ6]
    end
  end

  // latch bit of the written byte is dropped; writes leave the latch set
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      write_latch_r <= SMC_LATCH_RST; // [RQ9] [RQ24]
    end else if (byte_done && state_r == SMC_ST_OPCODE) begin
      if (dec_bus.cmd == SMC_CMD_SET_WRITE_LATCH) begin
        write_latch_r <= 1'b1; // [RQ7]
      end else if (dec_bus.cmd == SMC_CMD_CLEAR_WRITE_LATCH) begin
        write_latch_r <= 1'b0; // [RQ9]
      end
      // status, serial-number and special writes keep it as it is [RQ10]
    end
    // status write data never reaches this flop [RQ8]
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_nv_store <= 1'b0;
      o_nv_data  <= SMC_NV_RST;
    end else begin
      o_nv_store <= stat_wr_hit;
      if (stat_wr_hit) begin
        o_nv_data <= rx_byte & SMC_NV_MASK; // [RQ8] [RQ11]
      end
    end
  end

  assign o_status   = status_view;
  assign o_selected = active;

  ////////////////////////////////////////////////////////////////////////////
  // serial output
  // repeated status bytes follow as long as clocks keep coming
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_so      <= 1'b0;
      out_cnt_r <= 3'h0;
    end else if (state_r != SMC_ST_STAT_RD || cs_n_s) begin
      o_so      <= 1'b0;
      out_cnt_r <= 3'h0;
    end else if (sck_fall) begin
      o_so      <= status_view[3'h7 - out_cnt_r]; // [RQ21]
      out_cnt_r <= out_cnt_r + 3'h1;
    end
  end

  // released unless a status read is running; lets the host share the line
  assign o_so_oe = active && (state_r == SMC_ST_STAT_RD); // [RQ20] [RQ3]

  // select and serial clock are inputs only, so many slaves share one host [RQ2]

endmodule

// ---- design/smc_pkg.sv ----
/*
  Shared constants and types of the serial memory command and status front end.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package smc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // op-codes
  localparam logic [7:0] SMC_OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] SMC_OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] SMC_OP_STATUS_READ       = 8'h05;
  localparam logic [7:0] SMC_OP_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] SMC_OP_ARRAY_READ        = 8'h03;
  localparam logic [7:0] SMC_OP_ARRAY_WRITE       = 8'h02;
  localparam logic [7:0] SMC_OP_FAST_ARRAY_READ   = 8'h0B;
  localparam logic [7:0] SMC_OP_DEVICE_ID_READ    = 8'h9F;
  localparam logic [7:0] SMC_OP_UNIQUE_ID_READ    = 8'h4C;
  localparam logic [7:0] SMC_OP_SERIAL_NUM_WRITE  = 8'hC2;
  localparam logic [7:0] SMC_OP_SERIAL_NUM_READ   = 8'hC3;
  localparam logic [7:0] SMC_OP_SPECIAL_WRITE     = 8'h42;
  localparam logic [7:0] SMC_OP_SPECIAL_READ      = 8'h4B;
  localparam logic [7:0] SMC_OP_FAST_SPECIAL_READ = 8'h49;

  ////////////////////////////////////////////////////////////////////////////
  // status register layout
  localparam int         SMC_BIT_LOCK      = 7;
  localparam int         SMC_BIT_SPARE_HI  = 6;
  localparam int         SMC_BIT_SPARE_LO  = 4;
  localparam int         SMC_BIT_SIZE_HI   = 3;
  localparam int         SMC_BIT_SIZE_LO   = 2;
  localparam int         SMC_BIT_LATCH     = 1;
  localparam int         SMC_BIT_ZERO      = 0;
  localparam logic [7:0] SMC_NV_MASK       = 8'hFC;
  localparam logic       SMC_LATCH_RST     = 1'h0;
  localparam logic [7:0] SMC_NV_RST        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // framing
  localparam int         SMC_OP_BITS       = 8;
  localparam logic [2:0] SMC_CNT_LAST      = 3'h7;
  localparam int         SMC_SYNC_STAGES   = 2;
  // idle pin levels {wp_n, si, sck, cs_n}: deselected and unprotected
  localparam logic [3:0] SMC_PIN_IDLE      = 4'h9;

  typedef enum logic [3:0] {
    SMC_CMD_NONE,
    SMC_CMD_SET_WRITE_LATCH,
    SMC_CMD_CLEAR_WRITE_LATCH,
    SMC_CMD_STATUS_READ,
    SMC_CMD_STATUS_WRITE,
    SMC_CMD_ARRAY_READ,
    SMC_CMD_ARRAY_WRITE,
    SMC_CMD_FAST_ARRAY_READ,
    SMC_CMD_DEVICE_ID_READ,
    SMC_CMD_UNIQUE_ID_READ,
    SMC_CMD_SERIAL_NUM_WRITE,
    SMC_CMD_SERIAL_NUM_READ,
    SMC_CMD_SPECIAL_WRITE,
    SMC_CMD_SPECIAL_READ,
    SMC_CMD_FAST_SPECIAL_READ
  } smc_cmd_t;

endpackage

// ---- design/smc_dec_if.sv ----
/*
  Carrier between the frame engine and the op-code decoder.
  Assumes smc_pkg is compiled first.
*/
interface smc_dec_if;
  import smc_pkg::*;
  logic [7:0] code;
  smc_cmd_t   cmd;
  logic       known;
  modport dec (input code, output cmd, output known);
  modport user (output code, input cmd, input known);
endinterface

// ---- design/smc_sync.sv ----
/*
  Two-flop synchroniser with edge detection, one lane per bit.
  Assumes inputs are asynchronous to i_mclk.
*/
module smc_sync #(
  parameter int           W    = 1,
  // reset to the pin's idle level so no false edge follows reset
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // async input
  input  wire logic [W-1:0] i_d,
  // synchronised outputs
  output logic      [W-1:0] o_q,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  import smc_pkg::*;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  if (W < 1) begin : g_width_check
    $error("smc_sync: width must be at least one");
  end

  // meta_r is read only by sync_r
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
      prev_r <= IDLE;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_q    = sync_r;
  assign o_rise = sync_r & ~prev_r;
  assign o_fall = ~sync_r & prev_r;
endmodule

// ---- design/smc_opdec.sv ----
/*
  Op-code decoder: maps a received byte to a command kind.
  Assumes the byte is complete when read; purely combinational.
*/
module smc_opdec (
  // decode port
  smc_dec_if.dec dec
);
  import smc_pkg::*;

  always_comb begin
    dec.known = 1'b1;
    case (dec.code)
      SMC_OP_SET_WRITE_LATCH:   dec.cmd = SMC_CMD_SET_WRITE_LATCH;   // [RQ13]
      SMC_OP_CLEAR_WRITE_LATCH: dec.cmd = SMC_CMD_CLEAR_WRITE_LATCH; // [RQ13]
      SMC_OP_STATUS_READ:       dec.cmd = SMC_CMD_STATUS_READ;       // [RQ13]
      SMC_OP_STATUS_WRITE:      dec.cmd = SMC_CMD_STATUS_WRITE;      // [RQ14]
      SMC_OP_DEVICE_ID_READ:    dec.cmd = SMC_CMD_DEVICE_ID_READ;    // [RQ14]
      SMC_OP_UNIQUE_ID_READ:    dec.cmd = SMC_CMD_UNIQUE_ID_READ;    // [RQ14]
      SMC_OP_ARRAY_READ:        dec.cmd = SMC_CMD_ARRAY_READ;        // [RQ15]
      SMC_OP_ARRAY_WRITE:       dec.cmd = SMC_CMD_ARRAY_WRITE;       // [RQ15]
      SMC_OP_FAST_ARRAY_READ:   dec.cmd = SMC_CMD_FAST_ARRAY_READ;   // [RQ15]
      SMC_OP_SPECIAL_WRITE:     dec.cmd = SMC_CMD_SPECIAL_WRITE;     // [RQ16]
      SMC_OP_SPECIAL_READ:      dec.cmd = SMC_CMD_SPECIAL_READ;      // [RQ16]
      SMC_OP_FAST_SPECIAL_READ: dec.cmd = SMC_CMD_FAST_SPECIAL_READ; // [RQ16]
      SMC_OP_SERIAL_NUM_WRITE:  dec.cmd = SMC_CMD_SERIAL_NUM_WRITE;  // [RQ17]
      SMC_OP_SERIAL_NUM_READ:   dec.cmd = SMC_CMD_SERIAL_NUM_READ;   // [RQ17]
      default: begin
        // reserved codes execute nothing
        dec.cmd   = SMC_CMD_NONE; // [RQ12]
        dec.known = 1'b0;
      end
    endcase
  end
endmodule

// ---- tb/smc_top_monitor.sv ----
/*
  Port checker for the serial command and status front end.
  Assumes it is bound to smc_top and that everything runs on i_mclk.
*/
module smc_top_monitor (
  // clock and reset
  input wire logic              i_mclk,
  input wire logic              i_rst,
  // pins
  input wire logic              i_cs_n,
  input wire logic              i_wp_n,
  input wire logic              o_so,
  input wire logic              o_so_oe,
  // store and report
  input wire logic [7:0]        o_nv_data,
  input wire logic              o_nv_store,
  input wire logic              o_cmd_strobe,
  input wire logic [7:0]        o_cmd_code,
  input wire smc_pkg::smc_cmd_t o_cmd_kind,
  input wire logic              o_cmd_known,
  input wire logic              o_cmd_abort,
  input wire logic [7:0]        o_status,
  input wire logic              o_selected
);
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // five cycles covers the two-flop delay of the protect pin
  sequence lock_held;
    (o_status[7] && !i_wp_n)[*5];
  endsequence
  sequence took(smc_cmd_t k);
    o_cmd_strobe && o_cmd_kind == k;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_known_match: assert property (o_cmd_strobe |->
    o_cmd_known == (o_cmd_code inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h0B, 8'h9F, 8'h4C,
    8'hC2, 8'hC3, 8'h42, 8'h4B, 8'h49}) && (o_cmd_known || o_cmd_kind == SMC_CMD_NONE))
    else $error("op-code class wrong");
  a_latch_set: assert property (took(SMC_CMD_SET_WRITE_LATCH) |-> ##[0:1] o_status[1])
    else $error("write latch not set");
  a_latch_clear: assert property (took(SMC_CMD_CLEAR_WRITE_LATCH) |-> ##[0:1] !o_status[1])
    else $error("write latch not cleared");
  a_zero_bit: assert property (o_status[0] == 1'b0 && o_nv_data[1:0] == 2'h0)
    else $error("fixed zero bit set");
  a_store_keeps: assert property (o_nv_store |-> o_status[1] && $past(o_status[1]))
    else $error("store without latch or latch changed");
  a_store_mirror: assert property (o_nv_store |=> o_nv_data == (o_status & 8'hFC))
    else $error("stored image differs from status");
  a_lock_gate: assert property (lock_held |=> !o_nv_store)
    else $error("status write passed the lock");
  a_abort_quiet: assert property (o_cmd_abort |-> !o_cmd_strobe && $stable(o_status))
    else $error("partial op-code acted");
  a_standby_off: assert property (i_cs_n[*5] |-> !o_so_oe && !o_so && !o_selected)
    else $error("output active while deselected");
endmodule

bind smc_top smc_top_monitor u_mon (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe),
  .o_nv_data(o_nv_data), .o_nv_store(o_nv_store), .o_cmd_strobe(o_cmd_strobe), .o_cmd_code(o_cmd_code),
  .o_cmd_kind(o_cmd_kind), .o_cmd_known(o_cmd_known), .o_cmd_abort(o_cmd_abort), .o_status(o_status),
  .o_selected(o_selected)
);

// ---- tb/smc_host_model.sv ----
/*
  Serial host that frames op-codes and data, MSB first, 800 ns bit time.
  Assumes the caller steps it from the falling edge of i_mclk.
*/
module smc_host_model (
  // clock
  input  wire logic i_mclk,
  // serial pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  input  wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end

  // one mode per frame; sck idles at its level while deselected
  task automatic frame(input bit m3, input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge i_mclk);
    o_sck = m3;
    repeat (2) @(negedge i_mclk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    for (int k = 0; k < n; k++) begin
      if (m3) o_sck = 1'b0;
      o_si = tx[n-1-k];
      repeat (4) @(negedge i_mclk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_mclk);
      // sampled late in the bit so the slow synced output has settled
      rx = {rx[30:0], i_so};
      if (!m3) o_sck = 1'b0;
    end
    repeat (4) @(negedge i_mclk);
    o_cs_n = 1'b1;
    // released line: never leave the old value looking valid; so stays a separate pin
    o_si = ~o_si;
  endtask
endmodule

// ---- tb/smc_top_test.sv ----
/*
  Self-checking bench for smc_top against a small status and latch model.
  Assumes smc_pkg, the design and the host model are compiled first.
*/
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module smc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  logic       i_mclk, i_rst, i_wp_n, cs_n, sck, si, so, so_oe, nv_store, strobe, known, abort_p, sel, mode3;
  logic [7:0] i_nv_init, nv_data, code, status, st_nv, nvd;
  logic       latch;
  logic [31:0] rd, seed;
  smc_cmd_t   kind;
  int         err_count, samples_checked, store_cnt, abort_cnt;
  logic [7:0] ops [19] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h0B, 8'h9F, 8'h4C, 8'hC2,
                           8'hC3, 8'h42, 8'h4B, 8'h49, 8'hB9, 8'hC1, 8'hC6, 8'hCE, 8'hCF};

  smc_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .i_wp_n(i_wp_n), .i_nv_init(i_nv_init), .o_nv_data(nv_data), .o_nv_store(nv_store),
    .o_cmd_strobe(strobe), .o_cmd_code(code), .o_cmd_kind(kind), .o_cmd_known(known),
    .o_cmd_abort(abort_p), .o_status(status), .o_selected(sel), .o_mode3(mode3));
  smc_host_model u_host (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (nv_store === 1'b1) store_cnt++;
    if (abort_p === 1'b1) abort_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] est();
    return (st_nv & 8'hFC) | {6'h0, latch, 1'b0};
  endfunction
  task give_verdict;
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task run(input int n, input logic [31:0] tx);
    bit m;
    m = rnd() & 1;
    u_host.frame(m, n, tx, rd);
    `CHK("mode3", m, mode3)
    for (int i = 0; i < 20 && sel !== 1'b0; i++) @(negedge i_mclk);
    if (sel !== 1'b0) begin
      err_count++;
      $display("CHECK FAILED idle expected 0 seen %0h", sel);
      give_verdict;
    end
  endtask
  task do_reset(input logic [7:0] nv);
    i_rst = 1'b1;
    i_nv_init = nv;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    st_nv = nv;
    latch = 1'b0;
    nvd = 8'h00;
    `CHK("status", est(), status)
  endtask
  task cmd(input logic [7:0] op);
    int k;
    k = 14;
    for (int i = 0; i < 14; i++) if (ops[i] === op) k = i;
    run(8, {24'h0, op});
    if (op == 8'h06) latch = 1'b1;
    if (op == 8'h04) latch = 1'b0;
    `CHK("code", op, code)
    `CHK("kind", smc_cmd_t'(4'(k < 14 ? k + 1 : 0)), kind)
    `CHK("known", k < 14, known)
    `CHK("status", est(), status)
  endtask
  task sread;
    run(24, {8'h0, 8'h05, 16'h0});
    `CHK("read", {est(), est()}, rd[15:0])
  endtask
  task cmd_status_write(input logic [7:0] d);
    int n;
    n = store_cnt;
    run(16, {16'h0, 8'h01, d});
    if (latch && !(st_nv[7] && !i_wp_n)) begin
      st_nv = d & 8'hFC;
      nvd = st_nv;
      n++;
    end
    `CHK("status", est(), status)
    `CHK("stores", n, store_cnt)
    `CHK("image", nvd, nv_data)
  endtask
  task abort(input int n);
    int a;
    logic [7:0] c;
    a = abort_cnt;
    c = code;
    run(n, 32'h0);
    // abort pulse lands a cycle after select is seen high
    repeat (3) @(negedge i_mclk);
    `CHK("aborts", a + 1, abort_cnt)
    `CHK("code", c, code)
    `CHK("status", est(), status)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_wp_n = 1'b1;
    i_nv_init = 8'h00;
    seed = 32'd46;
    do_reset(rnd());
    // reserved codes sent on purpose to see them ignored
    for (int i = 0; i < 19; i++) cmd(ops[i]);
    sread;
    cmd(8'h04);
    cmd_status_write(rnd()); // refused without latch
    cmd(8'h06);
    repeat (4) begin
      i_wp_n = rnd() & 1;
      cmd_status_write(rnd());
      sread;
    end
    i_wp_n = 1'b1;
    cmd_status_write(8'h80);
    i_wp_n = 1'b0;
    cmd_status_write(8'h3F);
    i_wp_n = 1'b1;
    cmd_status_write(8'h5F);
    abort(5);
    abort(7);
    sread;
    do_reset(rnd());
    sread;
    give_verdict;
  end
endmodule
